// >>> core/nssz_alu.sv
// combinational swap and zero-test datapath
`timescale 1ns/100ps
`include "nssz_regs.svh"
module nssz_alu
   import nssz_pkg::*;
(
   input wire logic [2:0] op_i,
   input wire logic [7:0] mem_i,
   input wire logic [2:0] bit_sel_i,
   output logic [7:0] swap_o,
   output logic skip_o
);
   function automatic logic [7:0] nssz_swap(input logic [7:0] v);
      nssz_swap = {v[`NSSZ_NIB_LO_MSB:0], v[`NSSZ_NIB_HI_MSB:`NSSZ_NIB_HI_LSB]};
   endfunction

   always_comb begin
      swap_o = nssz_swap(mem_i);
      unique case (nssz_op_e'(op_i))
         NSSZ_OP_SZ, NSSZ_OP_SZA: skip_o = (mem_i == `NSSZ_ZERO_BYTE);
         NSSZ_OP_SZBIT: skip_o = ~mem_i[bit_sel_i];
         default: skip_o = 1'b0;
      endcase
   end
endmodule

// >>> core/nssz_exec.sv
// execution unit for nibble swap and skip-if-zero instructions
`timescale 1ns/100ps
`include "nssz_regs.svh"
module nssz_exec
   import nssz_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic exec_valid_i,
   input wire logic [2:0] op_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] mem_rdata_i,
   output logic busy_o,
   output logic acc_we_o,
   output logic [7:0] acc_wdata_o,
   output logic mem_we_o,
   output logic [7:0] mem_wdata_o,
   output logic skip_o,
   output logic dummy_o,
   output logic flags_we_o
);
   typedef struct packed {
      nssz_state_e st;
      logic busy;
      logic acc_we;
      logic [7:0] acc_wdata;
      logic mem_we;
      logic [7:0] mem_wdata;
      logic skip;
      logic dummy;
   } nssz_state_s;

   nssz_state_s q;
   nssz_state_s next_q;
   logic [7:0] swap_val;
   logic skip_hit;

   nssz_alu u_alu (
      .op_i(op_i),
      .mem_i(mem_rdata_i),
      .bit_sel_i(bit_sel_i),
      .swap_o(swap_val),
      .skip_o(skip_hit)
   );

   always_comb begin
      next_q = q;
      next_q.acc_we = 1'b0;
      next_q.mem_we = 1'b0;
      next_q.skip = 1'b0;
      next_q.dummy = 1'b0;
      next_q.busy = 1'b0;
      unique case (q.st)
         NSSZ_ST_RUN: begin
            if (exec_valid_i) begin
               unique case (nssz_op_e'(op_i))
                  NSSZ_OP_SWAPA: begin
                     next_q.acc_we = 1'b1;
                     next_q.acc_wdata = swap_val;
                  end
                  NSSZ_OP_SZ: begin
                     next_q.mem_we = 1'b1;
                     next_q.mem_wdata = mem_rdata_i;
                  end
                  NSSZ_OP_SZA: begin
                     next_q.acc_we = 1'b1;
                     next_q.acc_wdata = mem_rdata_i;
                  end
                  default: ;
               endcase
               // single cycle unless the test holds
               if (skip_hit) begin
                  next_q.skip = 1'b1;
                  next_q.busy = 1'b1;
                  next_q.st = NSSZ_ST_DUMMY;
               end // else no dummy
            end
         end
         NSSZ_ST_DUMMY: begin
            // fetched word is squashed here, busy stalls new issue
            next_q.dummy = 1'b1;
            next_q.st = NSSZ_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign busy_o = q.busy;
   assign acc_we_o = q.acc_we;
   assign acc_wdata_o = q.acc_wdata;
   assign mem_we_o = q.mem_we;
   assign mem_wdata_o = q.mem_wdata;
   assign skip_o = q.skip;
   assign dummy_o = q.dummy;
   // constant flop-free low: flags never written
   assign flags_we_o = 1'b0;
endmodule

// >>> core/nssz_pkg.sv
// types for the swap and skip-if-zero execution block
package nssz_pkg;
   typedef enum logic [2:0] {
      NSSZ_OP_NONE = 3'h0,
      NSSZ_OP_SWAPA = 3'h1,
      NSSZ_OP_SZ = 3'h2,
      NSSZ_OP_SZA = 3'h3,
      NSSZ_OP_SZBIT = 3'h4
   } nssz_op_e;
   typedef enum logic [0:0] {
      NSSZ_ST_RUN = 1'b0,
      NSSZ_ST_DUMMY = 1'b1
   } nssz_state_e;
endpackage

// >>> core/nssz_regs.svh
// constants for the swap and skip-if-zero execution block
`ifndef NSSZ_REGS_SVH
`define NSSZ_REGS_SVH
`define NSSZ_ZERO_BYTE 8'h00
`define NSSZ_NIB_LO_MSB 3
`define NSSZ_NIB_HI_MSB 7
`define NSSZ_NIB_HI_LSB 4
`define NSSZ_DUMMY_CYCLES 2'h1
`endif

// >>> verif/nssz_exec_properties.sv
// port checks for the swap and skip unit
`timescale 1ns/100ps
module nssz_exec_properties (input wire logic clock_i, nrst_i, exec_valid_i, busy_o,
   acc_we_o, mem_we_o, skip_o, dummy_o, flags_we_o, input wire logic [2:0] op_i, bit_sel_i,
   input wire logic [7:0] mem_rdata_i, acc_wdata_o, mem_wdata_o);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   logic [7:0] m;
   wire t = exec_valid_i && !busy_o;
   always_ff @(posedge clock_i) m <= mem_rdata_i;
   a_swap_nibbles: assert property (t && op_i == 3'h1 |=>
      acc_we_o && !mem_we_o && acc_wdata_o == {m[3:0], m[7:4]}) else $error("swap");
   a_zero_writeback: assert property (t && op_i == 3'h2 |=>
      mem_we_o && mem_wdata_o == m && skip_o == !m) else $error("sz");
   a_skip_dummy: assert property (skip_o |-> busy_o ##1 dummy_o ##1 !dummy_o)
      else $error("dummy");
   a_nonzero_run: assert property (t && op_i[1] && |mem_rdata_i |=> !skip_o)
      else $error("run");
   a_load_copy: assert property (t && op_i == 3'h3 |=>
      acc_we_o && acc_wdata_o == m && skip_o == !m) else $error("sza");
   a_bit_skip: assert property (t && op_i == 3'h4 && !mem_rdata_i[bit_sel_i]
      |=> skip_o) else $error("bit");
   a_flags_quiet: assert property (!flags_we_o) else $error("flags");
   a_dummy_cause: assert property (dummy_o |-> $past(skip_o)) else $error("cause");
endmodule
bind nssz_exec nssz_exec_properties i_nssz_exec_properties (.*);

// >>> verif/nssz_mem_model.sv
// data memory byte model facing the unit
`timescale 1ns/100ps
module nssz_mem_model (input wire logic clock_i, exec_valid_i, mem_we_o,
   input wire logic [7:0] mem_wdata_o, output logic [7:0] mem_rdata_i);
   logic [7:0] mem, junk = 8'h3C;
   // churn while unselected so stale data never looks valid
   assign mem_rdata_i = exec_valid_i ? mem : junk;
   always @(posedge clock_i) begin
      junk <= ~junk;
      if (mem_we_o) mem <= mem_wdata_o;
   end
endmodule

// >>> verif/testbench.sv
// bench for the swap and skip unit
`timescale 1ns/100ps
module testbench;
   logic clock_i = 0, nrst_i = 0, exec_valid_i = 0, busy_o, acc_we_o, mem_we_o, skip_o;
   logic dummy_o, flags_we_o;
   logic [2:0] op_i = 0, bit_sel_i = 0;
   logic [7:0] mem_rdata_i, acc_wdata_o, mem_wdata_o;
   int miscompares = 0, comparisons = 0, cycles = 0;
   always #5 clock_i = ~clock_i;
   nssz_exec i_nssz_exec (.*);
   nssz_mem_model i_nssz_mem_model (.*);
   task chk(input logic [7:0] g, e);
      comparisons++;
      miscompares += (g !== e);
      if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
   endtask
   task stop_test;
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // a swap follows each op; a dummy cycle must refuse it
   task run(input logic [2:0] o, b, input logic [7:0] v, a, input logic s);
      @(negedge clock_i);
      i_nssz_mem_model.mem = v;
      exec_valid_i = 1;
      op_i = o;
      bit_sel_i = b;
      @(negedge clock_i);
      op_i = 3'h1;
      chk({skip_o, busy_o, mem_we_o, acc_we_o}, {s, s, o == 3'h2, o[0]});
      if (o[0]) chk(acc_wdata_o, a);
      @(negedge clock_i);
      exec_valid_i = 0;
      chk({dummy_o, acc_we_o}, {s, !s});
   endtask
   initial begin
      #20 nrst_i = 1;
      run(3'h1, 3'h0, 8'hA5, 8'h5A, 0);
      run(3'h2, 3'h0, 8'h00, 8'h00, 1);
      run(3'h2, 3'h0, 8'h80, 8'h00, 0);
      run(3'h3, 3'h0, 8'h00, 8'h00, 1);
      run(3'h3, 3'h0, 8'h01, 8'h01, 0);
      run(3'h4, 3'h3, 8'hF7, 8'h00, 1);
      run(3'h4, 3'h3, 8'h08, 8'h00, 0);
      stop_test;
   end
   always @(posedge clock_i) if (++cycles > 200) begin
      miscompares++;
      stop_test;
   end
endmodule
